//--- core/bus_transceiver.v
// registered bidirectional 18-bit bus transceiver with AHB-Lite access,
// and the capture log FIFO that records clocked captures
// assumes: one clock clk, async active-high rst, one AHB-Lite master,
// side pins and control pins arrive asynchronously to clk
//
// Contract
// - while the a-to-b latch enable is high, side A flows to the a path.
// - with that latch enable low and its clock static, the a store holds.
// - with that latch enable low, each a-to-b clock rise stores side A.
// - side B is driven from the a path only while a_to_b_out_en is high.
// - the b-to-a path mirrors the a-to-b path with its own controls.
// - the a-to-b enable is active high, the b-to-a enable active low.
// - all 18 bits of a direction share one set of controls.
// - data keeps its polarity in both directions.
// - store clocks act regardless of output enables and port state.
// - with both outputs off, both latch enables low and clocks static, both stores hold.
// - with outputs off, a clock rise still stores that side's data.
// - with B driven and the a path latched, B shows the a store.
// - with B driven, an a clock rise stores A and shows it on B.
// - with B driven and the a latch open, B follows A.
// - with A driven, a b clock rise stores B and shows it on A.
// - with both driven and both latched, B shows a store, A b store.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "xcvr_defines.vh"

// ----------------------------------------------------------
// capture log fifo
// ----------------------------------------------------------
module capture_fifo #(
   parameter WIDTH = 19,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire clk,
   input wire rst,
   input wire inValid,
   output wire inReady,
   input wire [WIDTH-1:0] inData,
   output wire outValid,
   input wire outReady,
   output wire [WIDTH-1:0] outData
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wrPtr_ff;
   reg [AW:0] rdPtr_ff;
   wire doPush;
   wire doPop;
   wire full;
   wire empty;

   // pointer compare with wrap bit
   assign empty = (wrPtr_ff == rdPtr_ff);
   assign full = (wrPtr_ff[AW-1:0] == rdPtr_ff[AW-1:0]) &&
                 (wrPtr_ff[AW] != rdPtr_ff[AW]);
   assign inReady = ~full;
   assign outValid = ~empty;
   assign doPush = inValid & ~full;
   assign doPop = outReady & ~empty;
   assign outData = mem[rdPtr_ff[AW-1:0]];

   // storage array, no reset needed
   always @(posedge clk) begin
      if (doPush) begin
         mem[wrPtr_ff[AW-1:0]] <= inData;
      end
   end

   // pointers
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wrPtr_ff <= {(AW+1){1'b0}};
         rdPtr_ff <= {(AW+1){1'b0}};
      end else begin
         if (doPush) begin
            wrPtr_ff <= wrPtr_ff + {{AW{1'b0}}, 1'b1};
         end
         if (doPop) begin
            rdPtr_ff <= rdPtr_ff + {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule // capture_fifo

// ----------------------------------------------------------
// transceiver top
// ----------------------------------------------------------
module bus_transceiver (
   input wire clk,
   input wire rst,
   input wire a_to_b_out_en,
   input wire b_to_a_out_en_n,
   input wire a_to_b_latch_en,
   input wire b_to_a_latch_en,
   input wire a_to_b_clk,
   input wire b_to_a_clk,
   input wire [17:0] sideAIn,
   output wire [17:0] sideAOut,
   output wire sideAOe_n,
   input wire [17:0] sideBIn,
   output wire [17:0] sideBOut,
   output wire sideBOe_n,
   output wire logReady,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output wire [31:0] hrdata
);
   // synchroniser stages, one bit per pin
   reg [`XCVR_SYNC_W-1:0] sync1_ff;
   reg [`XCVR_SYNC_W-1:0] sync2_ff;
   reg [`XCVR_SYNC_W-1:0] sync3_ff;
   reg [`XCVR_SYNC_W-1:0] filt_ff;
   wire [`XCVR_SYNC_W-1:0] pinVec;
   wire [`XCVR_SYNC_W-1:0] nxt_filt;
   // registers
   reg [`CTRL_W-1:0] ctrl_ff;
   reg overflow_ff;
   reg [`XCVR_DW-1:0] aStore_ff;
   reg [`XCVR_DW-1:0] bStore_ff;
   reg aClkPrev_ff;
   reg bClkPrev_ff;
   reg aOe_n_ff;
   reg bOe_n_ff;
   // bus side
   reg dPhase_ff;
   reg dWrite_ff;
   reg [7:0] dAddr_ff;
   reg rdDone_ff;
   reg [31:0] hrdata_ff;
   reg [31:0] nxt_rdata;
   // selected controls
   wire swSel;
   wire aOutEn;
   wire bOutEnN;
   wire aLatch;
   wire bLatch;
   wire aClkLvl;
   wire bClkLvl;
   wire aRise;
   wire bRise;
   wire [`XCVR_DW-1:0] aData;
   wire [`XCVR_DW-1:0] bData;
   // log fifo hookup
   wire logInValid;
   wire [`LOG_W-1:0] logInData;
   wire logOutValid;
   wire [`LOG_W-1:0] logOutData;
   wire logPop;
   wire dropEvent;
   // bus decode
   wire addrTaken;
   wire rdStall;
   wire wrStrobe;
   wire rdStrobe;
   wire [5:0] filtCtrl;

   // register offset compare, used by read and write decode
   function isReg;
      input [7:0] addr;
      input [7:0] ofs;
      begin
         isReg = (addr == ofs);
      end
   endfunction

   // ----------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------

   // pin order: controls on top, then side A, then side B
   assign pinVec = {a_to_b_out_en, b_to_a_out_en_n, a_to_b_latch_en,
                    b_to_a_latch_en, a_to_b_clk, b_to_a_clk,
                    sideAIn, sideBIn};

   // a level counts once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < `XCVR_SYNC_W; gi = gi + 1) begin : g_filt
         assign nxt_filt[gi] = (sync2_ff[gi] == sync3_ff[gi]) ?
                               sync3_ff[gi] : filt_ff[gi];
      end
   endgenerate

   // three flops then agreement filter, drivers start disabled
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_ff <= `XCVR_SYNC_RESET;
         sync2_ff <= `XCVR_SYNC_RESET;
         sync3_ff <= `XCVR_SYNC_RESET;
         filt_ff <= `XCVR_SYNC_RESET;
      end else begin
         sync1_ff <= pinVec;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         filt_ff <= nxt_filt;
      end
   end

   assign filtCtrl = filt_ff[41:36];
   assign aData = filt_ff[35:18];
   assign bData = filt_ff[17:0];

   // ----------------------------------------------------------
   // control selection
   // ----------------------------------------------------------

   // software may take over all six controls at once
   assign swSel = ctrl_ff[`CTRL_SW_SEL];
   assign aOutEn = swSel ? ctrl_ff[`CTRL_A_OUT_EN] : filtCtrl[5];
   assign bOutEnN = swSel ? ctrl_ff[`CTRL_B_OUT_EN_N] : filtCtrl[4];
   assign aLatch = swSel ? ctrl_ff[`CTRL_A_LATCH_EN] : filtCtrl[3];
   assign bLatch = swSel ? ctrl_ff[`CTRL_B_LATCH_EN] : filtCtrl[2];
   assign aClkLvl = swSel ? ctrl_ff[`CTRL_A_CLK] : filtCtrl[1];
   assign bClkLvl = swSel ? ctrl_ff[`CTRL_B_CLK] : filtCtrl[0];

   // rising edges of the store clocks, not gated by enables
   assign aRise = aClkLvl & ~aClkPrev_ff;
   assign bRise = bClkLvl & ~bClkPrev_ff;

   // previous clock levels
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         aClkPrev_ff <= 1'b0;
         bClkPrev_ff <= 1'b0;
      end else begin
         aClkPrev_ff <= aClkLvl;
         bClkPrev_ff <= bClkLvl;
      end
   end

   // ----------------------------------------------------------
   // storage paths
   // ----------------------------------------------------------

   // a store: transparent, clocked or held; no reset
   always @(posedge clk) begin
      if (aLatch) begin
         aStore_ff <= aData;
      end else if (aRise) begin
         aStore_ff <= aData;
      end else begin
         aStore_ff <= aStore_ff;
      end
   end

   // b store mirrors the a store with its own controls
   always @(posedge clk) begin
      if (bLatch) begin
         bStore_ff <= bData;
      end else if (bRise) begin
         bStore_ff <= bData;
      end else begin
         bStore_ff <= bStore_ff;
      end
   end

   // output enables, one per direction, opposite sense
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         bOe_n_ff <= 1'b1;
         aOe_n_ff <= 1'b1;
      end else begin
         bOe_n_ff <= ~aOutEn;
         aOe_n_ff <= bOutEnN;
      end
   end

   // whole-width drive, no inversion
   assign sideBOut = aStore_ff;
   assign sideAOut = bStore_ff;
   assign sideBOe_n = bOe_n_ff;
   assign sideAOe_n = aOe_n_ff;

   // ----------------------------------------------------------
   // capture log
   // ----------------------------------------------------------

   // clocked captures go to the log; when both sides capture at once only the a side is logged
   assign logInValid = (aRise & ~aLatch) | (bRise & ~bLatch);
   assign logInData = (aRise & ~aLatch) ? {1'b0, aData} : {1'b1, bData};
   assign dropEvent = (logInValid & ~logReady) |
                      ((aRise & ~aLatch) & (bRise & ~bLatch));

   capture_fifo #(
      .WIDTH(`LOG_W),
      .DEPTH(`XCVR_LOG_DEPTH),
      .AW(`XCVR_LOG_AW)
   ) u_log (
      .clk(clk),
      .rst(rst),
      .inValid(logInValid),
      .inReady(logReady),
      .inData(logInData),
      .outValid(logOutValid),
      .outReady(logPop),
      .outData(logOutData)
   );

   // ----------------------------------------------------------
   // AHB-Lite slave
   // ----------------------------------------------------------

   assign addrTaken = hsel & htrans[1] & hready;
   assign rdStall = dPhase_ff & ~dWrite_ff & ~rdDone_ff;
   assign wrStrobe = dPhase_ff & dWrite_ff;
   assign rdStrobe = rdStall;
   assign logPop = rdStrobe & isReg(dAddr_ff, `OFS_LOG);
   assign hreadyout = ~rdStall;
   assign hresp = 1'b0;
   assign hrdata = hrdata_ff;

   // address phase capture and read wait state
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         dPhase_ff <= 1'b0;
         dWrite_ff <= 1'b0;
         dAddr_ff <= 8'h00;
         rdDone_ff <= 1'b0;
      end else begin
         if (hready) begin
            dPhase_ff <= addrTaken;
            dWrite_ff <= hwrite;
            dAddr_ff <= haddr[7:0];
         end
         rdDone_ff <= rdStall;
      end
   end

   // read data mux, unmapped reads as zero
   always @* begin
      nxt_rdata = 32'h00000000;
      if (isReg(dAddr_ff, `OFS_CTRL)) begin
         nxt_rdata[`CTRL_W-1:0] = ctrl_ff;
      end else if (isReg(dAddr_ff, `OFS_STATUS)) begin
         nxt_rdata[5:0] = {aOutEn, bOutEnN, aLatch, bLatch,
                           aClkLvl, bClkLvl};
         nxt_rdata[`STAT_LOG_EMPTY] = ~logOutValid;
         nxt_rdata[`STAT_LOG_FULL] = ~logReady;
         nxt_rdata[`STAT_OVERFLOW] = overflow_ff;
      end else if (isReg(dAddr_ff, `OFS_A_STORE)) begin
         nxt_rdata[`XCVR_DW-1:0] = aStore_ff;
      end else if (isReg(dAddr_ff, `OFS_B_STORE)) begin
         nxt_rdata[`XCVR_DW-1:0] = bStore_ff;
      end else if (isReg(dAddr_ff, `OFS_LOG)) begin
         nxt_rdata[`LOG_W-1:0] = logOutValid ? logOutData :
                                 {`LOG_W{1'b0}};
         nxt_rdata[`LOG_VALID] = logOutValid;
      end
   end

   // read data register
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         hrdata_ff <= 32'h00000000;
      end else if (rdStrobe) begin
         hrdata_ff <= nxt_rdata;
      end
   end

   // control register and overflow flag, set beats clear
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_ff <= `CTRL_RESET;
         overflow_ff <= 1'b0;
      end else begin
         if (wrStrobe && isReg(dAddr_ff, `OFS_CTRL)) begin
            ctrl_ff <= hwdata[`CTRL_W-1:0];
         end
         if (dropEvent) begin
            overflow_ff <= 1'b1;
         end else if (wrStrobe && isReg(dAddr_ff, `OFS_STATUS) &&
                      hwdata[`STAT_OVERFLOW]) begin
            overflow_ff <= 1'b0;
         end
      end
   end
endmodule // bus_transceiver

//--- core/xcvr_defines.vh
// constants of the registered bidirectional bus transceiver
// assumes inclusion by its bare name from the design file
`ifndef XCVR_DEFINES_VH
`define XCVR_DEFINES_VH

// ----------------------------------------------------------
// data path
// ----------------------------------------------------------
`define XCVR_DW 18
`define XCVR_LOG_DEPTH 8
`define XCVR_LOG_AW 3
`define XCVR_SYNC_W 42
// sync chain reset: side A enable pin idles high, so side A stays off
`define XCVR_SYNC_RESET 42'h10000000000

// ----------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_A_STORE 8'h08
`define OFS_B_STORE 8'h0C
`define OFS_LOG 8'h10

// ----------------------------------------------------------
// control register fields
// ----------------------------------------------------------
`define CTRL_A_OUT_EN 0
`define CTRL_B_OUT_EN_N 1
`define CTRL_A_LATCH_EN 2
`define CTRL_B_LATCH_EN 3
`define CTRL_A_CLK 4
`define CTRL_B_CLK 5
`define CTRL_SW_SEL 8
`define CTRL_W 9
`define CTRL_RESET 9'h002

// ----------------------------------------------------------
// status register fields
// ----------------------------------------------------------
`define STAT_LOG_EMPTY 8
`define STAT_LOG_FULL 9
`define STAT_OVERFLOW 10

// ----------------------------------------------------------
// capture log word fields
// ----------------------------------------------------------
`define LOG_DIR 18
`define LOG_VALID 31
`define LOG_W 19

`endif

//--- test/bus_partner.sv
// far-side model: places a word on each side bus while the
// transceiver leaves that bus undriven
// assumes the bench picks the words; the enabled driver wins
`timescale 1ns/100ps
module bus_partner (
   input wire [17:0] aWord,
   input wire [17:0] bWord,
   input wire [17:0] sideAOut,
   input wire sideAOe_n,
   input wire [17:0] sideBOut,
   input wire sideBOe_n,
   output wire [17:0] aLine,
   output wire [17:0] bLine
);
   // wired level of each bus
   assign aLine = sideAOe_n ? aWord : sideAOut;
   assign bLine = sideBOe_n ? bWord : sideBOut;
endmodule // bus_partner

//--- test/registered_bidir_bus_transceiver_test.sv
// self-checking bench of the transceiver against a queue model
// assumes bus_transceiver, bus_partner and the checker are built
`timescale 1ns/100ps
`include "xcvr_defines.vh"
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin \
   errors++; $display("wrong value at %0t: %h vs %h", $time, g, e); \
   end end
module registered_bidir_bus_transceiver_test;
   logic clk, rst, aEn, bEnN, aLat, bLat, aClk, bClk, ovf;
   logic [17:0] aWord, bWord, expA, expB, la, lb;
   wire [17:0] aLine, bLine, aOut, bOut;
   wire aOeN, bOeN, logRdy, hrdy, hresp;
   logic hsel, hwrite;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, q, r, w;
   wire [31:0] hrdata;
   logic [18:0] e;
   logic [18:0] logQ[$];
   int errors, checksDone, cyc;
   bus_transceiver u_bus_transceiver (
      .clk(clk),
      .rst(rst),
      .a_to_b_out_en(aEn),
      .b_to_a_out_en_n(bEnN),
      .a_to_b_latch_en(aLat),
      .b_to_a_latch_en(bLat),
      .a_to_b_clk(aClk),
      .b_to_a_clk(bClk),
      .sideAIn(aLine),
      .sideAOut(aOut),
      .sideAOe_n(aOeN),
      .sideBIn(bLine),
      .sideBOut(bOut),
      .sideBOe_n(bOeN),
      .logReady(logRdy),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hrdy),
      .hreadyout(hrdy),
      .hresp(hresp),
      .hrdata(hrdata)
   );
   bus_partner u_bus_partner (
      .aWord(aWord),
      .bWord(bWord),
      .sideAOut(aOut),
      .sideAOe_n(aOeN),
      .sideBOut(bOut),
      .sideBOe_n(bOeN),
      .aLine(aLine),
      .bLine(bLine)
   );
   // ---------------------------------------------
   // clock, timeout and verdict
   // ---------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 8000) begin
         errors++;
         printVerdict();
      end
   end
   task automatic printVerdict();
      $display("checks %0d, errors %0d", checksDone, errors);
      if (errors == 0 && checksDone > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ---------------------------------------------
   // bus and pin tasks
   // ---------------------------------------------
   // hready and read data taken at the rising edge that ends the wait
   task automatic waitRdy(output logic [31:0] d);
      do begin
         @(posedge clk);
      end while (hrdy !== 1'b1);
      d = hrdata;
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a,
         input logic [31:0] wd, output logic [31:0] rd);
      logic [31:0] x;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      waitRdy(x);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      waitRdy(rd);
   endtask
   task automatic pulse(input logic pa, input logic pb);
      aClk <= pa;
      bClk <= pb;
      repeat (4) @(posedge clk);
      aClk <= 1'b0;
      bClk <= 1'b0;
      repeat (10) @(posedge clk);
   endtask
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      {rst, aLat, bLat, bEnN} = 4'hF;
      {aEn, aClk, bClk, hsel, hwrite} = 5'h00;
      {htrans, hsize, haddr, hwdata} = {2'h0, 3'h2, 64'h0};
      void'($urandom(15444));
      aWord = 18'($urandom);
      bWord = 18'($urandom);
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (10) @(posedge clk);
      expA = aWord;
      expB = bWord;
      ovf = 1'b0;
      ahb(1'b0, `OFS_CTRL, 32'h0, q);
      `CHK(q, {23'h000000, `CTRL_RESET})
      ahb(1'b0, 8'h20, 32'h0, q);
      `CHK(q, 32'h00000000)
      w = 32'($urandom) & 32'h0000003F;
      ahb(1'b1, `OFS_CTRL, w, q);
      ahb(1'b0, `OFS_CTRL, 32'h0, q);
      `CHK(q, w)
      for (int i = 0; i < 24; i++) begin
         r = $urandom;
         aEn <= r[0];
         bEnN <= r[1];
         aLat <= r[2] & r[6];
         bLat <= r[3] & r[7] & !(r[2] & r[6]);
         aWord <= 18'($urandom);
         bWord <= 18'($urandom);
         repeat (10) @(posedge clk);
         if (aLat) expA = bEnN ? aWord : expB;
         if (bLat) expB = aEn ? expA : bWord;
         la = bEnN ? aWord : expB;
         lb = aEn ? expA : bWord;
         pulse(r[4] | !r[5], r[5]);
         if (!aLat && (r[4] | !r[5])) expA = la;
         if (!bLat && r[5]) expB = lb;
         if (aLat) expA = bEnN ? aWord : expB;
         if (bLat) expB = aEn ? expA : bWord;
         e = (!aLat && (r[4] | !r[5])) ? {1'b0, la} : {1'b1, lb};
         if (!aLat && !bLat && r[5] && (r[4] | !r[5])) ovf = 1'b1;
         if (!(aLat || (!r[5] && r[4] == 0 && 0)) || (!bLat && r[5]))
            if (!aLat && (r[4] | !r[5]) || !bLat && r[5])
               if (logQ.size() < 8) logQ.push_back(e);
               else ovf = 1'b1;
         ahb(1'b0, `OFS_A_STORE, 32'h0, q);
         `CHK(q[17:0], expA)
         ahb(1'b0, `OFS_B_STORE, 32'h0, q);
         `CHK(q[17:0], expB)
         if (aEn) `CHK(bOut, expA)
         if (!bEnN) `CHK(aOut, expB)
         `CHK(bOeN, !aEn)
         `CHK(aOeN, bEnN)
         `CHK(logRdy, logQ.size() < 8)
      end
      ahb(1'b0, `OFS_STATUS, 32'h0, q);
      `CHK(q[10:8], {ovf, logQ.size() == 8, logQ.size() == 0})
      ahb(1'b1, `OFS_STATUS, 32'h00000400, q);
      while (logQ.size() > 0) begin
         ahb(1'b0, `OFS_LOG, 32'h0, q);
         e = logQ.pop_front();
         `CHK({q[31], q[18:0]}, {1'b1, e})
      end
      ahb(1'b0, `OFS_LOG, 32'h0, q);
      `CHK(q[31], 1'b0)
      ahb(1'b0, `OFS_STATUS, 32'h0, q);
      `CHK(q[10:8], 3'h1)
      `CHK(q[5:0], {aEn, bEnN, aLat, bLat, 2'b00})
      `CHK(hresp, 1'b0)
      printVerdict();
   end
endmodule // registered_bidir_bus_transceiver_test

//--- test/xcvr_monitor.sv
// checker of the transceiver pin behaviour
// assumes bind into bus_transceiver, pins held 8+ clk per change
`timescale 1ns/100ps
module xcvr_monitor (
   input wire clk,
   input wire rst,
   input wire a_to_b_out_en,
   input wire b_to_a_out_en_n,
   input wire a_to_b_latch_en,
   input wire b_to_a_latch_en,
   input wire a_to_b_clk,
   input wire b_to_a_clk,
   input wire [17:0] sideAIn,
   input wire [17:0] sideAOut,
   input wire sideAOe_n,
   input wire [17:0] sideBIn,
   input wire [17:0] sideBOut,
   input wire sideBOe_n
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // ---------------------------------------------
   // steps of each path
   // ---------------------------------------------
   sequence aCap;
      !a_to_b_latch_en && $rose(a_to_b_clk) ##1
         (!a_to_b_latch_en && $stable(sideAIn))[*7];
   endsequence
   sequence bCap;
      !b_to_a_latch_en && $rose(b_to_a_clk) ##1
         (!b_to_a_latch_en && $stable(sideBIn))[*7];
   endsequence
   sequence aQuiet;
      !a_to_b_latch_en && $stable(a_to_b_clk);
   endsequence
   sequence bQuiet;
      !b_to_a_latch_en && $stable(b_to_a_clk);
   endsequence
   sequence aOpen;
      a_to_b_latch_en && $stable(sideAIn);
   endsequence
   sequence bOpen;
      b_to_a_latch_en && $stable(sideBIn);
   endsequence
   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   // drivers follow their enables
   side_b_drive_a: assert property (
      $stable(a_to_b_out_en)[*8] |-> sideBOe_n == !a_to_b_out_en)
      else $error("side B drive differs from its enable");
   side_a_drive_a: assert property (
      $stable(b_to_a_out_en_n)[*8] |-> sideAOe_n == b_to_a_out_en_n)
      else $error("side A drive differs from its enable");
   // clocked captures
   a_capture_a: assert property (
      aCap |-> sideBOut == sideAIn)
      else $error("a store missed a clocked capture");
   b_capture_a: assert property (
      bCap |-> sideAOut == sideBIn)
      else $error("b store missed a clocked capture");
   // latched stores hold
   a_hold_a: assert property (
      aQuiet[*8] ##1 aQuiet |-> $stable(sideBOut))
      else $error("a store changed while latched");
   b_hold_a: assert property (
      bQuiet[*8] ##1 bQuiet |-> $stable(sideAOut))
      else $error("b store changed while latched");
   // transparent paths follow the source
   a_flow_a: assert property (
      aOpen[*8] ##1 aOpen |-> sideBOut == sideAIn)
      else $error("a path not transparent");
   b_flow_a: assert property (
      bOpen[*8] ##1 bOpen |-> sideAOut == sideBIn)
      else $error("b path not transparent");
endmodule // xcvr_monitor

bind bus_transceiver xcvr_monitor u_xcvr_monitor (
   .clk(clk),
   .rst(rst),
   .a_to_b_out_en(a_to_b_out_en),
   .b_to_a_out_en_n(b_to_a_out_en_n),
   .a_to_b_latch_en(a_to_b_latch_en),
   .b_to_a_latch_en(b_to_a_latch_en),
   .a_to_b_clk(a_to_b_clk),
   .b_to_a_clk(b_to_a_clk),
   .sideAIn(sideAIn),
   .sideAOut(sideAOut),
   .sideAOe_n(sideAOe_n),
   .sideBIn(sideBIn),
   .sideBOut(sideBOut),
   .sideBOe_n(sideBOe_n)
);
